/* opcode_decode_adc_bitbranch.sv */
// Purpose: decode and execute add-with-carry and memory bit branches
// Assumes: APB3 slave, zero wait states, single clock
// Notes:   binary add only; decimal flag is stored, not applied
//
// Behaviour
// - status bits 7..0 are N, V, one, B, D, I, Z, C.
// - opcodes 0f-3f branch when zero-page bit 0-3 is clear.
// - opcodes 4f-7f branch when zero-page bit 4-7 is clear.
// - branch-on-clear keeps all flags; taken only if bit is zero.
// - add-with-carry sums A, M, C into A; sets N, V, Z, C; nine opcodes.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_adc_bitbranch #(
	parameter int ADDR_W = opdec_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   dec_adc,
	output logic                   dec_bit_clear,
	output logic                   dec_bit_set,
	output logic      [3:0]        dec_mode,
	output logic      [2:0]        dec_bit,
	output logic                   branch_taken,
	output logic      [7:0]        status_flags
);

	function automatic logic [3:0] adc_mode(input logic [7:0] op);
		unique case (op)
			opdec_pkg::OP_ADC_ABS:  adc_mode = opdec_pkg::AM_ABS;
			opdec_pkg::OP_ADC_ABSX: adc_mode = opdec_pkg::AM_ABSX;
			opdec_pkg::OP_ADC_ABSY: adc_mode = opdec_pkg::AM_ABSY;
			opdec_pkg::OP_ADC_IMM:  adc_mode = opdec_pkg::AM_IMM;
			opdec_pkg::OP_ADC_ZP:   adc_mode = opdec_pkg::AM_ZP;
			opdec_pkg::OP_ADC_ZPXI: adc_mode = opdec_pkg::AM_ZPXI;
			opdec_pkg::OP_ADC_ZPX:  adc_mode = opdec_pkg::AM_ZPX;
			opdec_pkg::OP_ADC_ZPI:  adc_mode = opdec_pkg::AM_ZPI;
			opdec_pkg::OP_ADC_INDY: adc_mode = opdec_pkg::AM_INDY;
			default:                adc_mode = opdec_pkg::AM_NONE;
		endcase
	endfunction : adc_mode

	function automatic logic is_bitbr(input logic [7:0] op);
		is_bitbr = (op[3:0] == opdec_pkg::BITBR_NIB);
	endfunction : is_bitbr

	// register file state
	logic [7:0]  opcode_q;
	logic [7:0]  opcode_d;
	logic [7:0]  acc_q;
	logic [7:0]  acc_d;
	logic [7:0]  mem_q;
	logic [7:0]  mem_d;
	logic [7:0]  status_q;
	logic [7:0]  status_d;
	logic        exec_q;
	logic        exec_d;
	// decode result state
	logic        adc_q;
	logic        adc_d;
	logic        bbr_q;
	logic        bbr_d;
	logic        bbs_q;
	logic        bbs_d;
	logic [3:0]  mode_q;
	logic [3:0]  mode_d;
	logic [2:0]  bit_q;
	logic [2:0]  bit_d;
	logic        taken_q;
	logic        taken_d;
	logic        valid_q;
	logic        valid_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	logic        wr_acc;
	logic        setup;
	logic        mapped;
	logic [8:0]  sum;
	logic [3:0]  amode;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	always_comb begin
		unique case (paddr[7:0])
			opdec_pkg::OFS_OPCODE, opdec_pkg::OFS_ACC, opdec_pkg::OFS_MEM,
			opdec_pkg::OFS_STATUS, opdec_pkg::OFS_CTRL, opdec_pkg::OFS_DECODE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// zero wait states keep the master simple
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;

	// read data is latched in the setup cycle so it is a flop in access
	always_comb begin
		prdata_d = prdata_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr[7:0])
				opdec_pkg::OFS_OPCODE: prdata_d[7:0] = opcode_q;
				opdec_pkg::OFS_ACC:    prdata_d[7:0] = acc_q;
				opdec_pkg::OFS_MEM:    prdata_d[7:0] = mem_q;
				opdec_pkg::OFS_STATUS: prdata_d[7:0] = status_q;
				opdec_pkg::OFS_DECODE: begin
					prdata_d[opdec_pkg::DF_ADC]                    = adc_q;
					prdata_d[opdec_pkg::DF_BBR]                    = bbr_q;
					prdata_d[opdec_pkg::DF_BBS]                    = bbs_q;
					prdata_d[opdec_pkg::DF_MODE +: 4]              = mode_q;
					prdata_d[opdec_pkg::DF_BIT +: 3]               = bit_q;
					prdata_d[opdec_pkg::DF_TAKEN]                  = taken_q;
					prdata_d[opdec_pkg::DF_VALID]                  = valid_q;
				end
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	assign sum   = {1'b0, acc_q} + {1'b0, mem_q} + {8'h00, status_q[opdec_pkg::ST_C]};
	assign amode = adc_mode(opcode_q);

	always_comb begin
		opcode_d = opcode_q;
		acc_d    = acc_q;
		mem_d    = mem_q;
		status_d = status_q;
		exec_d   = 1'b0;
		adc_d    = adc_q;
		bbr_d    = bbr_q;
		bbs_d    = bbs_q;
		mode_d   = mode_q;
		bit_d    = bit_q;
		taken_d  = taken_q;
		valid_d  = valid_q;
		if (wr_acc) begin
			unique case (paddr[7:0])
				opdec_pkg::OFS_OPCODE: opcode_d = pwdata[7:0];
				opdec_pkg::OFS_ACC:    acc_d    = pwdata[7:0];
				opdec_pkg::OFS_MEM:    mem_d    = pwdata[7:0];
				opdec_pkg::OFS_STATUS: status_d = pwdata[7:0];
				opdec_pkg::OFS_CTRL:   exec_d   = pwdata[opdec_pkg::CTRL_EXEC];
				default:               exec_d   = 1'b0;
			endcase
		end
		// exec never coincides with a write: it falls in the idle or setup cycle after the access
		if (exec_q) begin
			adc_d   = (amode != opdec_pkg::AM_NONE);
			bbr_d   = is_bitbr(opcode_q) && !opcode_q[7];
			bbs_d   = is_bitbr(opcode_q) && opcode_q[7];
			mode_d  = is_bitbr(opcode_q) ? opdec_pkg::AM_ZPREL : amode;
			bit_d   = opcode_q[6:4];
			taken_d = 1'b0;
			valid_d = 1'b1;
			if (is_bitbr(opcode_q)) begin
				// bit branches never touch status
				taken_d = mem_q[opcode_q[6:4]] == opcode_q[7];
			end else if (amode != opdec_pkg::AM_NONE) begin
				acc_d                       = sum[7:0];
				status_d[opdec_pkg::ST_C]   = sum[8];
				status_d[opdec_pkg::ST_Z]   = (sum[7:0] == 8'h00);
				status_d[opdec_pkg::ST_N]   = sum[7];
				status_d[opdec_pkg::ST_V]   = (acc_q[7] == mem_q[7]) && (sum[7] != acc_q[7]);
			end else begin
				valid_d = 1'b0;
			end
		end
		// user bit cannot be cleared
		status_d[opdec_pkg::ST_ONE] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opcode_q <= opdec_pkg::OPCODE_RST;
			acc_q    <= opdec_pkg::DATA_RST;
			mem_q    <= opdec_pkg::DATA_RST;
			status_q <= opdec_pkg::STATUS_RST;
			exec_q   <= 1'b0;
			adc_q    <= 1'b0;
			bbr_q    <= 1'b0;
			bbs_q    <= 1'b0;
			mode_q   <= opdec_pkg::AM_NONE;
			bit_q    <= 3'h0;
			taken_q  <= 1'b0;
			valid_q  <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			opcode_q <= opcode_d;
			acc_q    <= acc_d;
			mem_q    <= mem_d;
			status_q <= status_d;
			exec_q   <= exec_d;
			adc_q    <= adc_d;
			bbr_q    <= bbr_d;
			bbs_q    <= bbs_d;
			mode_q   <= mode_d;
			bit_q    <= bit_d;
			taken_q  <= taken_d;
			valid_q  <= valid_d;
			prdata_q <= prdata_d;
		end
	end

	assign dec_adc       = adc_q;
	assign dec_bit_clear = bbr_q;
	assign dec_bit_set   = bbs_q;
	assign dec_mode      = mode_q;
	assign dec_bit       = bit_q;
	assign branch_taken  = taken_q;
	assign status_flags  = status_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_status_one_bit: assert property (
		##1 status_q[opdec_pkg::ST_ONE]
	) else $error("status user bit is not one");

	a_bbr_low_decode: assert property (
		exec_q && opcode_q[3:0] == 4'hf && opcode_q[7:6] == 2'b00
		|=> bbr_q && !bbs_q && bit_q == $past(opcode_q[5:4], 1) && bit_q[2] == 1'b0
	) else $error("low bit-clear branch misdecoded");

	a_bbr_high_decode: assert property (
		exec_q && opcode_q[3:0] == 4'hf && opcode_q[7:6] == 2'b01
		|=> bbr_q && bit_q[2] && mode_q == opdec_pkg::AM_ZPREL
	) else $error("high bit-clear branch misdecoded");

	a_bbr_keep_flags: assert property (
		exec_q && opcode_q[3:0] == 4'hf && !opcode_q[7]
		|=> $stable(status_q) && $stable(acc_q)
		&& (taken_q == !$past(mem_q[opcode_q[6:4]], 1))
	) else $error("bit-clear branch altered flags or taken wrong");

	a_adc_sum_flags: assert property (
		exec_q && adc_mode(opcode_q) != opdec_pkg::AM_NONE
		|=> {status_q[opdec_pkg::ST_C], acc_q}
		== {1'b0, $past(acc_q, 1)} + {1'b0, $past(mem_q, 1)} + {8'h00, $past(status_q[0], 1)}
		&& status_q[opdec_pkg::ST_Z] == (acc_q == 8'h00)
		&& status_q[opdec_pkg::ST_N] == acc_q[7] && dec_adc
	) else $error("add-with-carry result or flags wrong");

	a_adc_imm_mode: assert property (
		exec_q && opcode_q == 8'h69 |=> mode_q == opdec_pkg::AM_IMM ##1 mode_q == opdec_pkg::AM_IMM
	) else $error("immediate add mode wrong");

	a_bbs_decode: assert property (
		exec_q && opcode_q[3:0] == 4'hf && opcode_q[7]
		|=> bbs_q && !bbr_q && $stable(status_q)
		&& taken_q == $past(mem_q[opcode_q[6:4]], 1)
	) else $error("bit-set branch misdecoded");

	a_no_exec_hold: assert property (
		!exec_q && !wr_acc |=> $stable(status_q)
	) else $error("status changed without cause");

	a_adc_overflow: assert property (
		exec_q && adc_mode(opcode_q) != opdec_pkg::AM_NONE
		|=> status_q[opdec_pkg::ST_V]
		== (($past(acc_q[7], 1) == $past(mem_q[7], 1)) && (acc_q[7] != $past(acc_q[7], 1)))
	) else $error("add-with-carry overflow flag wrong");

	a_adc_other_flags: assert property (
		exec_q && adc_mode(opcode_q) != opdec_pkg::AM_NONE
		|=> status_q[5:2] == $past(status_q[5:2], 1) && valid_q && !bbr_q && !bbs_q && mode_q != opdec_pkg::AM_NONE
	) else $error("add-with-carry touched a flag it must keep");

	a_refused_opcode: assert property (
		exec_q && adc_mode(opcode_q) == opdec_pkg::AM_NONE && !is_bitbr(opcode_q)
		|=> !valid_q && !adc_q && !bbr_q && !bbs_q && !taken_q && mode_q == opdec_pkg::AM_NONE
		&& $stable(status_q) && $stable(acc_q)
	) else $error("foreign opcode changed decode or state");

	a_bbr_class: assert property (
		exec_q && is_bitbr(opcode_q) && !opcode_q[7]
		|=> valid_q && !adc_q && mode_q == opdec_pkg::AM_ZPREL && bit_q == $past(opcode_q[6:4], 1)
	) else $error("bit-clear branch class wrong");

	a_bbs_keep_acc: assert property (
		exec_q && is_bitbr(opcode_q) && opcode_q[7]
		|=> valid_q && !adc_q && $stable(acc_q) && mode_q == opdec_pkg::AM_ZPREL
		&& bit_q == $past(opcode_q[6:4], 1)
	) else $error("bit-set branch class or accumulator wrong");

	a_status_write: assert property (
		wr_acc && paddr == opdec_pkg::OFS_STATUS
		|=> status_q[7:6] == $past(pwdata[7:6], 1) && status_q[4:0] == $past(pwdata[4:0], 1)
		&& status_q[opdec_pkg::ST_ONE]
	) else $error("status write not stored");

	a_status_read: assert property (
		psel && penable && !pwrite && paddr == opdec_pkg::OFS_STATUS
		|-> prdata[7:0] == $past(status_q, 1) && prdata[31:8] == 24'h00_0000 && prdata[opdec_pkg::ST_ONE]
	) else $error("status read data wrong");

endmodule : opcode_decode_adc_bitbranch
`default_nettype wire

/* opcode_decode_adc_bitbranch_test.sv */
// Purpose: self-checking bench for the opcode decoder over APB
// Assumes: APB slave answers via pready; exec results two edges after CTRL write
// Notes:   decode is read one idle cycle after exec so results are fresh
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_adc_bitbranch_test;
	logic        clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        dec_adc, dec_bit_clear, dec_bit_set, branch_taken;
	logic [3:0]  dec_mode;
	logic [2:0]  dec_bit;
	logic [7:0]  status_flags;
	logic [31:0] rd, dv, ex;
	logic        err, tk, v;
	logic [8:0]  sum;
	logic [7:0]  a, m;
	int          error_cnt, compares, cycles;
	logic [7:0]  ops[9] = '{8'h6d, 8'h7d, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75, 8'h72, 8'h71};

	opcode_decode_adc_bitbranch DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dec_adc(dec_adc), .dec_bit_clear(dec_bit_clear), .dec_bit_set(dec_bit_set),
		.dec_mode(dec_mode), .dec_bit(dec_bit), .branch_taken(branch_taken), .status_flags(status_flags));

	always #12.5 clk = ~clk;

	task wrap_up;
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	// whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// no release at the end, so back-to-back calls never drive psel twice per step
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		logic rdy;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(posedge clk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
		end
	endtask : apb

	task idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : idle

	task run(input logic [7:0] op, input logic [7:0] ac, input logic [7:0] mv, input logic [7:0] st);
		apb(1'b1, opdec_pkg::OFS_OPCODE, {24'h0, op});
		apb(1'b1, opdec_pkg::OFS_ACC, {24'h0, ac});
		apb(1'b1, opdec_pkg::OFS_MEM, {24'h0, mv});
		apb(1'b1, opdec_pkg::OFS_STATUS, {24'h0, st});
		apb(1'b1, opdec_pkg::OFS_CTRL, 32'h1);
		idle();
		apb(1'b0, opdec_pkg::OFS_DECODE, 32'h0);
		dv = rd;
	endtask : run

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		compares = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, opdec_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h20, "status reset");
		apb(1'b1, opdec_pkg::OFS_STATUS, 32'h0);
		apb(1'b0, opdec_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h20, "status bit5");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped err");
		apb(1'b1, opdec_pkg::OFS_DECODE, 32'hffffffff);
		apb(1'b0, opdec_pkg::OFS_DECODE, 32'h0);
		chk(rd, 32'h0, "decode read-only");
		for (int i = 0; i < 16; i++) begin
			m = i[3] ? 8'h33 : 8'h5a;
			tk = (m[i[2:0]] == i[3]);
			run({i[3:0], 4'hf}, 8'h11, m, 8'hc3);
			ex = 32'h2000 | {19'h0, tk, 1'b0, i[2:0], opdec_pkg::AM_ZPREL, 1'b0, i[3], !i[3], 1'b0};
			chk(dv, ex, "bit branch decode");
			chk({24'h0, branch_taken, dec_bit, dec_mode}, {24'h0, tk, i[2:0], 4'ha}, "branch ports");
			chk({29'h0, dec_adc, dec_bit_clear, dec_bit_set}, {29'h0, 1'b0, !i[3], i[3]}, "class");
			chk({24'h0, status_flags}, 32'he3, "flags kept");
			apb(1'b0, opdec_pkg::OFS_ACC, 32'h0);
			chk(rd, 32'h11, "acc kept");
		end
		for (int i = 0; i < 9; i++) begin
			a = 8'(i * 8'h1d + 8'h40);
			m = (i == 6) ? 8'(8'h00 - a) : 8'(8'h43 + i * 8'h0b);
			sum = {1'b0, a} + {1'b0, m} + {8'h0, i[0]};
			v = (a[7] == m[7]) && (sum[7] != a[7]);
			run(ops[i], a, m, {7'h06, i[0]});
			chk(dv & 32'h30f7, {18'h0, 2'b10, 4'h0, 4'(i + 1), 4'h1}, "adc decode");
			chk({28'h0, dec_adc, dec_bit_clear, dec_bit_set, branch_taken}, 32'h8, "adc class");
			chk({24'h0, status_flags}, {24'h0, sum[7], v, 4'b1011, sum[7:0] == 8'h0, sum[8]}, "adc flags");
			apb(1'b0, opdec_pkg::OFS_ACC, 32'h0);
			chk(rd, {24'h0, sum[7:0]}, "adc sum");
		end
		run(8'h29, 8'h11, 8'h22, 8'h81);
		chk(dv, 32'h0000_0200, "foreign opcode");
		chk({24'h0, status_flags}, 32'ha1, "foreign flags");
		apb(1'b0, opdec_pkg::OFS_ACC, 32'h0);
		chk(rd, 32'h11, "foreign acc");
		idle();
		wrap_up();
	end
endmodule : opcode_decode_adc_bitbranch_test
`default_nettype wire

/* opdec_pkg.sv */
// Purpose: shared constants of the opcode decoder block
// Assumes: 32-bit APB register window, byte addresses
// Notes:   addressing-mode codes are local to this block
package opdec_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_OPCODE    = 8'h00;
	localparam logic [7:0]  OFS_ACC       = 8'h04;
	localparam logic [7:0]  OFS_MEM       = 8'h08;
	localparam logic [7:0]  OFS_STATUS    = 8'h0c;
	localparam logic [7:0]  OFS_CTRL      = 8'h10;
	localparam logic [7:0]  OFS_DECODE    = 8'h14;
	// status register bit positions
	localparam int          ST_C          = 0;
	localparam int          ST_Z          = 1;
	localparam int          ST_I          = 2;
	localparam int          ST_D          = 3;
	localparam int          ST_B          = 4;
	localparam int          ST_ONE        = 5;
	localparam int          ST_V          = 6;
	localparam int          ST_N          = 7;
	localparam logic [7:0]  STATUS_RST    = 8'h20;
	localparam logic [7:0]  OPCODE_RST    = 8'hea;
	localparam logic [7:0]  DATA_RST      = 8'h00;
	// control register
	localparam int          CTRL_EXEC     = 0;
	// decode register field positions
	localparam int          DF_ADC        = 0;
	localparam int          DF_BBR        = 1;
	localparam int          DF_BBS        = 2;
	localparam int          DF_MODE       = 4;
	localparam int          DF_BIT        = 8;
	localparam int          DF_TAKEN      = 12;
	localparam int          DF_VALID      = 13;
	// add-with-carry opcodes
	localparam logic [7:0]  OP_ADC_ABS    = 8'h6d;
	localparam logic [7:0]  OP_ADC_ABSX   = 8'h7d;
	localparam logic [7:0]  OP_ADC_ABSY   = 8'h79;
	localparam logic [7:0]  OP_ADC_IMM    = 8'h69;
	localparam logic [7:0]  OP_ADC_ZP     = 8'h65;
	localparam logic [7:0]  OP_ADC_ZPXI   = 8'h61;
	localparam logic [7:0]  OP_ADC_ZPX    = 8'h75;
	localparam logic [7:0]  OP_ADC_ZPI    = 8'h72;
	localparam logic [7:0]  OP_ADC_INDY   = 8'h71;
	// bit-branch opcodes: low nibble f, bit 7 picks set/clear
	localparam logic [3:0]  BITBR_NIB     = 4'hf;
	// addressing mode codes
	localparam logic [3:0]  AM_NONE       = 4'h0;
	localparam logic [3:0]  AM_ABS        = 4'h1;
	localparam logic [3:0]  AM_ABSX       = 4'h2;
	localparam logic [3:0]  AM_ABSY       = 4'h3;
	localparam logic [3:0]  AM_IMM        = 4'h4;
	localparam logic [3:0]  AM_ZP         = 4'h5;
	localparam logic [3:0]  AM_ZPXI       = 4'h6;
	localparam logic [3:0]  AM_ZPX        = 4'h7;
	localparam logic [3:0]  AM_ZPI        = 4'h8;
	localparam logic [3:0]  AM_INDY       = 4'h9;
	localparam logic [3:0]  AM_ZPREL      = 4'ha;
endpackage : opdec_pkg
